/* File: rtl/ir_ctl_pkg.sv */
// Package for the shared control of the short and long IR timers.
// Assumes a single 100 MHz system clock and a plain register port.
package ir_ctl_pkg;

   // ==========================================================
   // Register map
   localparam logic [11:0] COMMON_CTRL_ADDR = 12'hd01;
   localparam logic [11:0] TIMER_STATUS_ADDR = 12'hd40;
   localparam logic [7:0] COMMON_CTRL_RESET = 8'h00;

   // ==========================================================
   // Field positions of the common control register and the interrupt mask register
   localparam int MODE_BIT = 7;
   localparam int ROUTE_BIT = 6;
   localparam int FUNC_HI = 5;
   localparam int FUNC_LO = 4;
   localparam int SUB_HI = 3;
   localparam int SUB_LO = 2;
   localparam int INIT_SHORT_BIT = 1;
   localparam int INIT_LONG_BIT = 0;
   localparam int IMR_EXTERNAL_REQUEST_ONE_BIT = 2;

   // ==========================================================
   // Field encodings
   localparam logic [1:0] LOGIC_AND = 2'h0;
   localparam logic [1:0] LOGIC_OR = 2'h1;
   localparam logic [1:0] LOGIC_NOR = 2'h2;
   localparam logic [1:0] LOGIC_NAND = 2'h3;
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam logic [1:0] SUB_NORMAL = 2'h0;
   localparam logic [1:0] SUB_ALTERNATE = 2'h1;
   localparam logic [1:0] SUB_FORCE_LOW = 2'h2;
   localparam logic [1:0] SUB_FORCE_HIGH = 2'h3;
   localparam logic [1:0] FILT_NONE = 2'h0;
   localparam logic [1:0] FILT_SHORT = 2'h1;
   localparam logic [1:0] FILT_LONG = 2'h2;

   // ==========================================================
   // Glitch filter timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int FILT_SHORT_CYC = 4;
   localparam int FILT_LONG_CYC = 8;
   localparam int FILT_CNT_W = 4;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic rise;
      logic fall;
   } edge_ev_s;

endpackage : ir_ctl_pkg

/* File: rtl/ir_glitch_filter.sv */
// Glitch filter for the demodulator input.
// Assumes the input is already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ir_glitch_filter (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Input and settings
   input wire logic raw_i,
   input wire logic [1:0] filt_sel_i,
   // Filtered level
   output logic level_o
);
   import ir_ctl_pkg::*;

   logic cand_q, level_q;
   logic [FILT_CNT_W-1:0] cnt_q;
   logic [FILT_CNT_W-1:0] limit;

   // ==========================================================
   // Counted limit, one below the widest pulse rejected
   always_comb begin
      case (filt_sel_i)
         FILT_SHORT: limit = FILT_CNT_W'(FILT_SHORT_CYC - 1);
         FILT_LONG: limit = FILT_CNT_W'(FILT_LONG_CYC - 1);
         default: limit = '0;
      endcase
   end

   // Level accepted once stable beyond the limit
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cand_q <= 1'b0;
         cnt_q <= '0;
         level_q <= 1'b0;
      end else if (raw_i != cand_q) begin
         cand_q <= raw_i;
         cnt_q <= '0;
         if (limit == '0) begin
            level_q <= raw_i;
         end
      end else if (cnt_q < limit) begin
         cnt_q <= cnt_q + 1'b1;
      end else begin
         level_q <= cand_q;
      end
   end

   assign level_o = level_q;
endmodule : ir_glitch_filter
`default_nettype wire

/* File: rtl/ir_edge_detect.sv */
// Edge detector on the filtered demodulator level.
// Assumes a level already in the clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module ir_edge_detect (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Level and polarity
   input wire logic level_i,
   input wire logic [1:0] edge_sel_i,
   // One-cycle edge pulses
   output ir_ctl_pkg::edge_ev_s ev_o
);
   import ir_ctl_pkg::*;

   logic prev_q;
   logic rise, fall;

   // Previous level
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level_i;
      end
   end

   assign rise = level_i & ~prev_q;
   assign fall = ~level_i & prev_q;

   // Polarity selection, reserved code detects nothing
   always_comb begin
      ev_o.rise = rise & ((edge_sel_i == EDGE_RISE) | (edge_sel_i == EDGE_BOTH));
      ev_o.fall = fall & ((edge_sel_i == EDGE_FALL) | (edge_sel_i == EDGE_BOTH));
   end
endmodule : ir_edge_detect
`default_nettype wire

/* File: rtl/ir_timer_common_control.sv */
// Shared control of the short and long IR timers: output combining,
// submodes, demodulator input selection, filtering and edge flags.
// Assumes timer engines outside supply outputs and enable/count states.
//
// Overview of operation
// - Top bit picks transmit (0) or demodulation (1) for both timers.
// - Transmit: bit 6 routes combined timer output or port value to pin.
// - Demodulation: bit 6 picks port3 pin1 (0) or port2 pin0 (1) input.
// - Port3 pin1 source with mask bit set raises external request one.
// - Transmit: bits 5:4 choose AND, OR, NOR, NAND combining.
// - Combining field survives stop-mode recovery.
// - Demodulation: bits 5:4 choose falling, rising, both, reserved edges.
// - Submode 00 normal, 01 alternating; writing 00 ends alternating.
// - After a transmit write of 00/01, long output holds inverse of bit 0 until counting.
// - Demodulation: bits 3:2 set no filter, 4 or 8 cycle rejection.
// - Bit 1 sets short initial level; opposite is driven while disabled.
// - Demodulation: bits 1/0 set on rise/fall, cleared by writing 1.
`timescale 1ns/1ps
`default_nettype none
module ir_timer_common_control (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic stop_recovery_i,
   // Register port
   input wire ir_ctl_pkg::reg_req_s req_i,
   output logic [7:0] rdata_o,
   // Timer engine side
   input wire logic short_timer_output_i,
   input wire logic long_timer_output_i,
   input wire logic short_timer_enabled_i,
   input wire logic long_timer_counting_i,
   // Pins and interrupt
   input wire logic port3_pin6_data_i,
   input wire logic port3_pin1_input_i,
   input wire logic port2_pin0_input_i,
   input wire logic [7:0] interrupt_mask_register_i,
   output logic port3_pin6_output_o,
   output logic short_timer_output_o,
   output logic long_timer_output_o,
   output logic alternating_submode_o,
   output logic demod_mode_o,
   output logic demod_rise_o,
   output logic demod_fall_o,
   output logic external_request_one_o
);
   import ir_ctl_pkg::*;

   logic mode_q, route_q;
   logic [1:0] func_q, sub_q;
   logic init_short_q, init_long_q;
   logic rise_flag_q, fall_flag_q;
   logic long_hold_q;
   logic p31_s1_q, p31_s2_q, p31_prev_q;
   logic p20_s1_q, p20_s2_q;
   logic p31_event;
   logic demod_src;
   logic filt_level;
   edge_ev_s ev;
   logic ctrl_wr, ctrl_rd;
   logic stat_rd;
   logic [7:0] ctrl_view;
   logic [7:0] rdata_q;
   logic pin_q, short_q, long_q, alt_q, rise_q, fall_q, irq_q, mode_out_q;
   logic short_eff, long_eff;

   // Two-input combiner by field code
   // Codes follow the combining field directly
   function automatic logic combine(input logic [1:0] f, input logic a, input logic b);
      case (f)
         LOGIC_AND: combine = a & b;
         LOGIC_OR: combine = a | b;
         LOGIC_NOR: combine = ~(a | b);
         default: combine = ~(a & b);
      endcase
   endfunction

   // Strobe qualified by one register address
   function automatic logic addr_hit(input logic strobe, input logic [11:0] a,
                                     input logic [11:0] target);
      addr_hit = strobe && (a == target);
   endfunction

   // Decoded register accesses
   assign ctrl_wr = addr_hit(req_i.wr, req_i.addr, COMMON_CTRL_ADDR);
   assign ctrl_rd = addr_hit(req_i.rd, req_i.addr, COMMON_CTRL_ADDR);
   assign stat_rd = addr_hit(req_i.rd, req_i.addr, TIMER_STATUS_ADDR);

   // ==========================================================
   // Control register
   // Mode, route, submode and initial level storage
   // Stop recovery clears all but the combining field
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q <= COMMON_CTRL_RESET[MODE_BIT];
         route_q <= COMMON_CTRL_RESET[ROUTE_BIT];
         sub_q <= COMMON_CTRL_RESET[SUB_HI:SUB_LO];
         init_short_q <= COMMON_CTRL_RESET[INIT_SHORT_BIT];
         init_long_q <= COMMON_CTRL_RESET[INIT_LONG_BIT];
      end else if (stop_recovery_i) begin
         mode_q <= COMMON_CTRL_RESET[MODE_BIT];
         route_q <= COMMON_CTRL_RESET[ROUTE_BIT];
         sub_q <= COMMON_CTRL_RESET[SUB_HI:SUB_LO];
         init_short_q <= COMMON_CTRL_RESET[INIT_SHORT_BIT];
         init_long_q <= COMMON_CTRL_RESET[INIT_LONG_BIT];
      end else if (ctrl_wr) begin
         mode_q <= req_i.wdata[MODE_BIT];
         route_q <= req_i.wdata[ROUTE_BIT];
         sub_q <= req_i.wdata[SUB_HI:SUB_LO];
         init_short_q <= req_i.wdata[INIT_SHORT_BIT];
         init_long_q <= req_i.wdata[INIT_LONG_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         func_q <= COMMON_CTRL_RESET[FUNC_HI:FUNC_LO];
      end else if (ctrl_wr) begin
         func_q <= req_i.wdata[FUNC_HI:FUNC_LO];
      end
   end

   // ==========================================================
   // Demodulator input path
   // Source selection between the synchronised pins
   assign demod_src = route_q ? p20_s2_q : p31_s2_q;

   // Glitch filter on the selected level
   ir_glitch_filter u_filter (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .raw_i(demod_src),
      .filt_sel_i(sub_q),
      .level_o(filt_level)
   );

   ir_edge_detect u_edge (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .level_i(filt_level),
      .edge_sel_i(func_q),
      .ev_o(ev)
   );

   // Edge flags, set wins over write-one clear
   // Leaving demodulation drops stale flags, so a
   // later return starts with both flags clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rise_flag_q <= 1'b0;
         fall_flag_q <= 1'b0;
      end else if (!mode_q || stop_recovery_i) begin
         rise_flag_q <= 1'b0;
         fall_flag_q <= 1'b0;
      end else begin
         if (ev.rise) begin
            rise_flag_q <= 1'b1;
         end else if (ctrl_wr && req_i.wdata[INIT_SHORT_BIT]) begin
            rise_flag_q <= 1'b0;
         end
         if (ev.fall) begin
            fall_flag_q <= 1'b1;
         end else if (ctrl_wr && req_i.wdata[INIT_LONG_BIT]) begin
            fall_flag_q <= 1'b0;
         end
      end
   end

   // Port3 pin1 synchroniser, demodulator and request paths
   // Raw pins reach only a first flop, so the source mux,
   // filter and request logic never see a metastable level
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p31_s1_q <= 1'b0;
         p31_s2_q <= 1'b0;
         p31_prev_q <= 1'b0;
      end else begin
         p31_s1_q <= port3_pin1_input_i;
         p31_s2_q <= p31_s1_q;
         p31_prev_q <= p31_s2_q;
      end
   end

   // Port2 pin0 synchroniser for the demodulator source
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p20_s1_q <= 1'b0;
         p20_s2_q <= 1'b0;
      end else begin
         p20_s1_q <= port2_pin0_input_i;
         p20_s2_q <= p20_s1_q;
      end
   end

   // One-cycle change on the synchronised port3 pin1
   assign p31_event = p31_s2_q != p31_prev_q;

   // ==========================================================
   // Transmit path
   // Long output held until counting starts
   // A transmit-mode write of submode 00 or 01 re-arms the hold; software
   // keeps the long timer stopped while it changes submode
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         long_hold_q <= 1'b1;
      end else if (ctrl_wr && !req_i.wdata[MODE_BIT] && !req_i.wdata[SUB_HI]) begin
         long_hold_q <= 1'b1;
      end else if (long_timer_counting_i) begin
         long_hold_q <= 1'b0;
      end
   end

   // Short output idles opposite its initial level
   // The opposite level makes enabling give a transition
   assign short_eff = short_timer_enabled_i ? short_timer_output_i : ~init_short_q;

   // Forced levels, held inverse
   // Forcing overrides both the hold and the counting output
   always_comb begin
      case (sub_q)
         SUB_FORCE_LOW: long_eff = 1'b0;
         SUB_FORCE_HIGH: long_eff = 1'b1;
         default: long_eff = long_hold_q ? ~init_long_q : long_timer_output_i;
      endcase
   end

   // ==========================================================
   // Registered outputs
   // Timer outputs idle low in demodulation so that no
   // stray carrier leaves through them
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_q <= 1'b0;
         short_q <= 1'b0;
         long_q <= 1'b0;
         alt_q <= 1'b0;
         mode_out_q <= 1'b0;
      end else begin
         if (!mode_q && route_q) begin
            pin_q <= combine(func_q, short_eff, long_eff);
         end else begin
            pin_q <= port3_pin6_data_i;
         end
         short_q <= mode_q ? 1'b0 : short_eff;
         long_q <= mode_q ? 1'b0 : long_eff;
         // Alternating active only on submode 01
         alt_q <= !mode_q && (sub_q == SUB_ALTERNATE);
         mode_out_q <= mode_q;
      end
   end

   // Edge flags and interrupt request
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         rise_q <= rise_flag_q;
         fall_q <= fall_flag_q;
         // Pin event raises external request one
         // Any change of the synchronised pin is one event
         irq_q <= mode_q && !route_q && interrupt_mask_register_i[IMR_EXTERNAL_REQUEST_ONE_BIT]
                  && p31_event;
      end
   end

   // ==========================================================
   // Read path
   // Bits 1:0 carry the flags in demodulation, which hides
   // the stored initial levels until transmit mode returns
   always_comb begin
      ctrl_view = {mode_q, route_q, func_q, sub_q, init_short_q, init_long_q};
      if (mode_q) begin
         ctrl_view[INIT_SHORT_BIT] = rise_flag_q;
         ctrl_view[INIT_LONG_BIT] = fall_flag_q;
      end
   end

   // Read data one cycle after strobe, zero elsewhere
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 8'h00;
      end else if (ctrl_rd) begin
         rdata_q <= ctrl_view;
      end else if (stat_rd) begin
         rdata_q <= {5'h00, filt_level, long_hold_q, alt_q};
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata_o = rdata_q;
   assign port3_pin6_output_o = pin_q;
   assign short_timer_output_o = short_q;
   assign long_timer_output_o = long_q;
   assign alternating_submode_o = alt_q;
   assign demod_mode_o = mode_out_q;
   assign demod_rise_o = rise_q;
   assign demod_fall_o = fall_q;
   assign external_request_one_o = irq_q;
endmodule : ir_timer_common_control
`default_nettype wire

/* File: tb/ir_pin_source.sv */
// Receiver model driving the two demodulator pins.
// Assumes calls come just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ir_pin_source (
   // Clock
   input wire logic clk_i,
   // Receiver pins, idle high
   output logic port3_pin1_o,
   output logic port2_pin0_o
);
   // Idle level
   initial begin
      port3_pin1_o = 1'b1;
      port2_pin0_o = 1'b1;
   end

   // Low pulse of a given width
   task automatic pulse(input logic sel, input int width);
      @(posedge clk_i);
      if (sel) port2_pin0_o <= 1'b0;
      else port3_pin1_o <= 1'b0;
      repeat (width) @(posedge clk_i);
      if (sel) port2_pin0_o <= 1'b1;
      else port3_pin1_o <= 1'b1;
   endtask
endmodule // ir_pin_source
`default_nettype wire

/* File: tb/ir_ctl_monitor.sv */
// Checker for the shared IR timer control.
// Assumes the control byte changes only by writes and stop recovery.
`timescale 1ns/1ps
`default_nettype none
module ir_ctl_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic stop_recovery_i,
   // Register port
   input wire ir_ctl_pkg::reg_req_s req_i,
   input wire logic [7:0] rdata_o,
   // Inputs watched
   input wire logic short_timer_enabled_i,
   input wire logic port3_pin6_data_i,
   input wire logic [7:0] interrupt_mask_register_i,
   // Outputs watched
   input wire logic port3_pin6_output_o,
   input wire logic short_timer_output_o,
   input wire logic long_timer_output_o,
   input wire logic alternating_submode_o,
   input wire logic demod_mode_o,
   input wire logic demod_rise_o,
   input wire logic external_request_one_o
);
   import ir_ctl_pkg::*;
   logic [7:0] ctl_q;
   logic [1:0] age_q;
   logic ctl_wr;
   logic calm;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // ==========================================================
   // Shadow control byte and cycles since it changed
   assign ctl_wr = req_i.wr && (req_i.addr == COMMON_CTRL_ADDR);
   assign calm = (age_q == 2'h3);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_q <= 8'h00;
         age_q <= 2'h0;
      end else begin
         if (stop_recovery_i) begin
            ctl_q <= {2'h0, ctl_q[5:4], 4'h0};
         end else if (ctl_wr) begin
            ctl_q <= req_i.wdata;
         end
         if (stop_recovery_i || ctl_wr) begin
            age_q <= 2'h0;
         end else if (!calm) begin
            age_q <= age_q + 2'h1;
         end
      end
   end

   // ==========================================================
   // Assertions
   mode_copy_a: assert property (calm |-> demod_mode_o == ctl_q[7])
      else $error("mode output differs from control");
   pin_route_a: assert property (calm && !ctl_q[7] && !ctl_q[6]
      |-> port3_pin6_output_o == $past(port3_pin6_data_i)) else $error("pin not port data");
   alt_flag_a: assert property (calm
      |-> alternating_submode_o == (!ctl_q[7] && ctl_q[3:2] == SUB_ALTERNATE))
      else $error("alternating output wrong");
   long_force_a: assert property (calm && !ctl_q[7] && ctl_q[3]
      |-> long_timer_output_o == ctl_q[2]) else $error("forced long output wrong");
   short_idle_a: assert property (calm && !ctl_q[7] && !short_timer_enabled_i
      && !$past(short_timer_enabled_i) |-> short_timer_output_o == !ctl_q[1])
      else $error("idle short output wrong");
   irq_gate_a: assert property (external_request_one_o
      |-> $past(ctl_q[7]) && !$past(ctl_q[6]) && $past(interrupt_mask_register_i[2]))
      else $error("request one without its conditions");
   rise_mode_a: assert property ($rose(demod_rise_o) |-> demod_mode_o)
      else $error("rise flag outside demodulation");
   flag_clear_a: assert property (ctl_wr && ctl_q[7] && req_i.wdata[7]
      && req_i.wdata[1] |-> ##2 !demod_rise_o) else $error("rise flag not cleared");
   rd_idle_a: assert property (!(req_i.rd && (req_i.addr == COMMON_CTRL_ADDR
      || req_i.addr == TIMER_STATUS_ADDR)) |=> rdata_o == 8'h00) else $error("stray read data");
endmodule // ir_ctl_monitor

bind ir_timer_common_control ir_ctl_monitor u_mon (.clk_i, .rst_n_i, .stop_recovery_i,
   .req_i, .rdata_o, .short_timer_enabled_i, .port3_pin6_data_i, .interrupt_mask_register_i,
   .port3_pin6_output_o, .short_timer_output_o, .long_timer_output_o,
   .alternating_submode_o, .demod_mode_o, .demod_rise_o, .external_request_one_o);
`default_nettype wire

/* File: tb/ir_timer_common_control_test.sv */
// Self-checking bench for the shared IR timer control.
// Assumes the pin source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module ir_timer_common_control_test;
   import ir_ctl_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic stop_recovery_i = 1'b0;
   reg_req_s req_i = '0;
   logic short_timer_output_i = 1'b0;
   logic long_timer_output_i = 1'b0;
   logic short_timer_enabled_i = 1'b1;
   logic long_timer_counting_i = 1'b1;
   logic port3_pin6_data_i = 1'b0;
   logic [7:0] interrupt_mask_register_i = 8'h00;
   logic port3_pin1_input_i, port2_pin0_input_i, port3_pin6_output_o;
   logic short_timer_output_o, long_timer_output_o, alternating_submode_o;
   logic demod_mode_o, demod_rise_o, demod_fall_o, external_request_one_o;
   logic [7:0] rdata_o;
   logic [7:0] exp_q[$];
   logic rd_pend = 1'b0;
   int bad_count = 0;
   int cmp_count = 0;
   int irq_cnt = 0;

   // ==========================================================
   // Design, pin source and clock
   ir_timer_common_control u_dut (.clk_i, .rst_n_i, .stop_recovery_i, .req_i, .rdata_o,
      .short_timer_output_i, .long_timer_output_i, .short_timer_enabled_i,
      .long_timer_counting_i, .port3_pin6_data_i, .port3_pin1_input_i, .port2_pin0_input_i,
      .interrupt_mask_register_i, .port3_pin6_output_o, .short_timer_output_o,
      .long_timer_output_o, .alternating_submode_o, .demod_mode_o, .demod_rise_o,
      .demod_fall_o, .external_request_one_o);
   ir_pin_source u_src (.clk_i, .port3_pin1_o(port3_pin1_input_i),
      .port2_pin0_o(port2_pin0_input_i));
   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // ==========================================================
   // Tasks
   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic bus(input logic [11:0] a, input logic [7:0] d, input logic w);
      req_i <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk_i);
      req_i <= '0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus(a, d, 1'b1);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(a, 8'h00, 1'b0);
   endtask
   task automatic wset(input logic [7:0] d);
      wr(COMMON_CTRL_ADDR, d);
      repeat (3) @(posedge clk_i);
   endtask
   task automatic edges(input logic sel, input int w, input logic [7:0] e);
      u_src.pulse(sel, w);
      repeat (20) @(posedge clk_i);
      rd(COMMON_CTRL_ADDR, e);
   endtask
   function automatic logic comb(input logic [1:0] f, input logic s, input logic l);
      case (f)
         LOGIC_AND: return s & l;
         LOGIC_OR: return s | l;
         LOGIC_NOR: return ~(s | l);
         default: return ~(s & l);
      endcase
   endfunction

   // ==========================================================
   // Read data checker and request counter
   always @(posedge clk_i) begin
      if (rd_pend) begin
         cmp_count++;
         if (rdata_o !== exp_q[0]) begin
            bad_count++;
            $display("ERROR read data expected %h seen %h", exp_q[0], rdata_o);
         end
         void'(exp_q.pop_front());
      end
      rd_pend <= req_i.rd;
      if (external_request_one_o === 1'b1) irq_cnt++;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      $display("ERROR run length expected end seen timeout");
      end_sim();
   end

   // ==========================================================
   // Main sequence
   initial begin
      logic s;
      logic l;
      logic [7:0] b;
      void'($urandom(58));
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(COMMON_CTRL_ADDR, COMMON_CTRL_RESET);
      wr(12'hd02, 8'hff);
      rd(12'hd02, 8'h00);
      rd(COMMON_CTRL_ADDR, 8'h00);
      for (int k = 0; k < 12; k++) begin
         s = 1'($urandom);
         l = 1'($urandom);
         short_timer_output_i <= s;
         long_timer_output_i <= l;
         port3_pin6_data_i <= 1'($urandom);
         wset({2'h1, 2'(k % 4), 4'h0});
         chk("combined pin", comb(2'(k % 4), s, l), port3_pin6_output_o);
         wset(8'h00);
         chk("port pin", port3_pin6_data_i, port3_pin6_output_o);
      end
      wset(8'h08);
      chk("forced low", 1'b0, long_timer_output_o);
      wset(8'h0c);
      chk("forced high", 1'b1, long_timer_output_o);
      wset(8'h04);
      chk("alternating on", 1'b1, alternating_submode_o);
      rd(TIMER_STATUS_ADDR, 8'h05);
      wset(8'h00);
      chk("alternating off", 1'b0, alternating_submode_o);
      long_timer_counting_i <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         wset({4'h0, 2'(k / 2), 1'b0, 1'(k)});
         chk("long hold", ~1'(k), long_timer_output_o);
      end
      long_timer_output_i <= 1'b1;
      long_timer_counting_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("long counting", 1'b1, long_timer_output_o);
      short_timer_enabled_i <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         wset({6'h0, 1'(k), 1'b0});
         chk("short idle", ~1'(k), short_timer_output_o);
      end
      short_timer_enabled_i <= 1'b1;
      wr(COMMON_CTRL_ADDR, 8'h7e);
      stop_recovery_i <= 1'b1;
      @(posedge clk_i);
      stop_recovery_i <= 1'b0;
      rd(COMMON_CTRL_ADDR, 8'h30);
      short_timer_enabled_i <= 1'b0;
      long_timer_counting_i <= 1'b0;
      interrupt_mask_register_i <= 8'h04;
      for (int e = 0; e < 4; e++) begin
         b = {2'h2, 2'(e), 4'h0};
         wr(COMMON_CTRL_ADDR, b);
         irq_cnt = 0;
         edges(1'b0, 6, b | {6'h0, 1'(e == 1 || e == 2), 1'(e == 0 || e == 2)});
         chk("request count", 1'b1, irq_cnt == 2);
         chk("rise flag", 1'(e == 1 || e == 2), demod_rise_o);
         chk("fall flag", 1'(e == 0 || e == 2), demod_fall_o);
         wr(COMMON_CTRL_ADDR, b | 8'h03);
         rd(COMMON_CTRL_ADDR, b);
      end
      wr(COMMON_CTRL_ADDR, 8'he0);
      irq_cnt = 0;
      edges(1'b0, 6, 8'he0);
      chk("request count", 1'b1, irq_cnt == 0);
      edges(1'b1, 6, 8'he3);
      for (int k = 1; k < 3; k++) begin
         b = {4'he, 2'(k), 2'h0};
         wr(COMMON_CTRL_ADDR, b | 8'h03);
         edges(1'b1, 4 * k, b);
         edges(1'b1, 4 * k + 1, b | 8'h03);
      end
      repeat (2) @(posedge clk_i);
      end_sim();
   end
endmodule // ir_timer_common_control_test
`default_nettype wire
